//--- hdl/gpb_defs.svh
// constants for the global parameter and interrupt setup bank
// Function
// - protection level 0..3, four meanings
// - dropping disassembly protection erases program first
// - coordinate persistence 1 mirrors writes to nonvolatile
// - restore user variables at boot unless inhibited
// - answer second address; zero disables it
// - reversal inverts motor, encoder; normal mode only
// - program counter readable, shows executing command
// - 32-bit millisecond counter, loadable by write
// - random read gives new value; write seeds
// - suppression drops direct replies except three reads
// - suppression never persisted, cleared at startup
// - 256 user variables; first 56 restorable
// - lowest pending interrupt number served first
// - three periodic timers, period in milliseconds
// - four inputs, two-bit edge select per input
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH
// banks
`define GPB_BANK_GLOBAL   8'h00
`define GPB_BANK_USERVAR  8'h02
`define GPB_BANK_IRQ      8'h03
// bank 0 parameter numbers
`define GPB_P_PROTECT     8'h51
`define GPB_P_COORD       8'h54
`define GPB_P_INHIBIT     8'h55
`define GPB_P_SECADDR     8'h57
`define GPB_P_REVERSE     8'h5A
`define GPB_P_APPSTATE    8'h80
`define GPB_P_LOADMODE    8'h81
`define GPB_P_PC          8'h82
`define GPB_P_TICK        8'h84
`define GPB_P_RANDOM      8'h85
`define GPB_P_SUPPRESS    8'hFF
// bank 3 parameter numbers, also the interrupt numbers
`define GPB_P_TIMER0      8'h00
`define GPB_P_TIMER1      8'h01
`define GPB_P_TIMER2      8'h02
`define GPB_P_STOPLEFT    8'h1B
`define GPB_P_STOPRIGHT   8'h1C
`define GPB_P_INPUT0      8'h27
`define GPB_P_INPUT1      8'h28
// user variables
`define GPB_UV_NV_COUNT   8'h38
// edge select codes
`define GPB_EDGE_OFF      2'h0
`define GPB_EDGE_RISE     2'h1
`define GPB_EDGE_FALL     2'h2
`define GPB_EDGE_BOTH     2'h3
// reset values
`define GPB_RST_PROTECT   2'h0
`define GPB_RST_BIT       1'h0
`define GPB_RST_SECADDR   8'h00
`define GPB_RST_WORD      32'h0000_0000
`define GPB_RST_SEED      32'h1234_5678
// timing
`define GPB_CLK_PERIOD_NS   10
`define GPB_TICK_PERIOD_NS  1000000
`define GPB_MS_CYCLES       (`GPB_TICK_PERIOD_NS / `GPB_CLK_PERIOD_NS)
`endif

//--- hdl/gpb_pkg.sv
// types for the global parameter and interrupt setup bank
package gpb_pkg;
   // command kinds seen on the telegram side
   typedef enum logic [2:0] {
      GPB_OTHER_CMD              = 3'h0,
      GPB_WRITE_GLOBAL_PARAM_CMD = 3'h1,
      GPB_READ_GLOBAL_PARAM_CMD  = 3'h2,
      GPB_READ_AXIS_PARAM_CMD    = 3'h3,
      GPB_READ_IO_CMD            = 3'h4
   } gpb_cmd_type;
   // one decoded direct-mode command
   typedef struct packed {
      logic        valid;
      gpb_cmd_type cmd;
      logic [7:0]  bank;
      logic [7:0]  param;
      logic [31:0] value;
   } gpb_req_type;
   // answer to a command
   typedef struct packed {
      logic        valid;
      logic        error;
      logic        sendReply;
      logic [31:0] data;
   } gpb_rsp_type;
   // startup sequence, gray along the restore path
   typedef enum logic [1:0] {
      GPB_BOOT_WAIT    = 2'b00,
      GPB_BOOT_RESTORE = 2'b01,
      GPB_BOOT_RUN     = 2'b11
   } gpb_boot_type;
endpackage : gpb_pkg

//--- hdl/gpb_param_bank.sv
// global parameter, user variable and interrupt setup bank
`timescale 1ns/100ps
`include "gpb_defs.svh"
module gpb_param_bank
   import gpb_pkg::*;
#(
   parameter int MS_CYCLES = `GPB_MS_CYCLES
)
(
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire gpb_req_type req,
   output logic             reqReady,
   output gpb_rsp_type      rsp,
   input  wire logic        nvInhibitRestore,
   output logic             restoreReq,
   input  wire logic        restoreDone,
   input  wire logic        nvLoadValid,
   input  wire logic [7:0]  nvLoadIdx,
   input  wire logic [31:0] nvLoadData,
   output logic             eraseProgramReq,
   output logic [1:0]       protectionLevel,
   input  wire logic        coordWrite,
   output logic             coordNvWrite,
   input  wire logic [7:0]  rxAddr,
   input  wire logic [7:0]  primaryAddr,
   output logic             addrMatch,
   input  wire logic        stepDirMode,
   input  wire logic        motorDirIn,
   input  wire logic        encDirIn,
   output logic             motorDirOut,
   output logic             encDirOut,
   input  wire logic [1:0]  appState,
   input  wire logic        loadMode,
   input  wire logic [31:0] progCounter,
   input  wire logic        stopLeftPin,
   input  wire logic        stopRightPin,
   input  wire logic        input0Pin,
   input  wire logic        input1Pin,
   output logic             irqValid,
   output logic [7:0]       irqNum,
   input  wire logic        irqAck
);
   localparam int NTMR = 3;                    // periodic timers
   localparam int NPIN = 4;                    // edge-triggered inputs
   localparam int NIRQ = NTMR + NPIN;          // pending slots, priority order
   localparam logic [7:0] IRQ_NUMS [NIRQ] = '{`GPB_P_TIMER0, `GPB_P_TIMER1,
      `GPB_P_TIMER2, `GPB_P_STOPLEFT, `GPB_P_STOPRIGHT, `GPB_P_INPUT0, `GPB_P_INPUT1};
   localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

   gpb_boot_type bootState_q;                  // startup sequence
   logic [1:0]   protect_q;                    // protection level
   logic         coord_q;                      // coordinate persistence
   logic         inhibit_q;                    // restore inhibit
   logic [7:0]   secAddr_q;                    // second target address
   logic         reverse_q;                    // shaft reversal
   logic         suppress_q;                   // reply suppression
   logic [31:0]  tick_q;                       // millisecond counter
   logic [31:0]  rnd_q;                        // generator state
   logic [31:0]  prescale_q;                   // cycles within a millisecond
   logic         msTick;                       // one pulse per millisecond
   logic [31:0]  userVar [256];                // user variables
   logic [31:0]  period_q [NTMR];              // timer periods
   logic [31:0]  tcnt_q [NTMR];                // timer counts
   logic [1:0]   edgeSel_q [NPIN];             // edge selections
   logic [NPIN-1:0] pinRaw;                    // raw pins
   logic [NPIN-1:0] sync1_q, sync2_q, prev_q;  // synchroniser and last sample
   logic [NIRQ-1:0] fire;                      // events this cycle
   logic [NIRQ-1:0] pend_q;                    // pending interrupts
   logic [2:0]   servIdx;                      // slot being offered
   logic         acc;                          // command taken
   logic         isWrite;                      // taken command writes
   logic         isRead;                       // taken command reads a global
   logic [31:0]  rdData;                       // read mux
   logic         rdErr;                        // bad parameter
   logic         replyOk;                      // reply allowed

   // decode of one bank and parameter pair for writes
   function automatic logic wrHit(input logic [7:0] b, input logic [7:0] p);
      return isWrite && (req.bank == b) && (req.param == p);
   endfunction : wrHit

   // lowest set slot, which has the lowest interrupt number
   function automatic logic [2:0] lowestIdx(input logic [NIRQ-1:0] v);
      lowestIdx = 3'h0;
      for (int i = NIRQ - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            lowestIdx = 3'(i);
         end
      end
   endfunction : lowestIdx

   // xorshift step; never reaches zero from a nonzero state
   function automatic logic [31:0] rndStep(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      y = y ^ (y << 5);
      return y;
   endfunction : rndStep

   // commands wait until the startup restore has finished
   assign reqReady = (bootState_q == GPB_BOOT_RUN);
   assign acc      = req.valid && reqReady;
   assign isWrite  = acc && (req.cmd == GPB_WRITE_GLOBAL_PARAM_CMD);
   assign isRead   = acc && (req.cmd == GPB_READ_GLOBAL_PARAM_CMD);

   // startup: restore unless inhibited, no restore on a later change
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         bootState_q <= GPB_BOOT_WAIT;
      else
         case (bootState_q)
            GPB_BOOT_WAIT:
               bootState_q <= nvInhibitRestore ? GPB_BOOT_RUN : GPB_BOOT_RESTORE;
            GPB_BOOT_RESTORE:
               if (restoreDone)
                  bootState_q <= GPB_BOOT_RUN;
            GPB_BOOT_RUN:
               bootState_q <= GPB_BOOT_RUN;
            default:
               bootState_q <= GPB_BOOT_WAIT;
         endcase
   end
   assign restoreReq = (bootState_q == GPB_BOOT_RESTORE);

   // restore inhibit follows the stored copy at boot, then software
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         inhibit_q <= `GPB_RST_BIT;
      else if (bootState_q == GPB_BOOT_WAIT)
         inhibit_q <= nvInhibitRestore;
      else if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_INHIBIT))
         inhibit_q <= req.value[0];
   end

   // protection level; erase request when disassembly lock is dropped
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         protect_q       <= `GPB_RST_PROTECT;
         eraseProgramReq <= 1'b0;
      end
      else
      begin
         eraseProgramReq <= 1'b0;
         if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_PROTECT))
         begin
            protect_q       <= req.value[1:0];
            eraseProgramReq <= protect_q[0] && !req.value[0];
         end
      end
   end
   assign protectionLevel = protect_q;

   // simple configuration bits; suppression comes up cleared
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         coord_q    <= `GPB_RST_BIT;
         secAddr_q  <= `GPB_RST_SECADDR;
         reverse_q  <= `GPB_RST_BIT;
         suppress_q <= `GPB_RST_BIT;
      end
      else
      begin
         if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_COORD))
            coord_q <= req.value[0];
         if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_SECADDR))
            secAddr_q <= req.value[7:0];
         if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_REVERSE))
            reverse_q <= req.value[0];
         if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_SUPPRESS))
            suppress_q <= req.value[0];
      end
   end

   // coordinate writes mirrored only in persistent mode
   assign coordNvWrite = coordWrite && coord_q;
   // second address zero never matches
   assign addrMatch = (rxAddr == primaryAddr)
                      || ((secAddr_q != 8'h00) && (rxAddr == secAddr_q));
   // step/direction mode bypasses the reversal
   assign motorDirOut = motorDirIn ^ (reverse_q && !stepDirMode);
   assign encDirOut   = encDirIn ^ (reverse_q && !stepDirMode);

   // millisecond prescaler
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         prescale_q <= `GPB_RST_WORD;
      else if (prescale_q >= MS_LAST)
         prescale_q <= `GPB_RST_WORD;
      else
         prescale_q <= prescale_q + 32'h1;
   end
   assign msTick = (prescale_q >= MS_LAST);

   // tick counter; a load wins over the increment in the same cycle
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         tick_q <= `GPB_RST_WORD;
      else if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_TICK))
         tick_q <= req.value;
      else if (msTick)
         tick_q <= tick_q + 32'h1;
   end

   // generator; zero seed replaced since xorshift would stick there
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rnd_q <= `GPB_RST_SEED;
      else if (wrHit(`GPB_BANK_GLOBAL, `GPB_P_RANDOM))
         rnd_q <= (req.value == 32'h0) ? `GPB_RST_SEED : req.value;
      else if (isRead && (req.bank == `GPB_BANK_GLOBAL) && (req.param == `GPB_P_RANDOM))
         rnd_q <= rndStep(rnd_q);
   end

   // user variables; boot loads reach only the persistent part
   always_ff @(posedge core_clk)
   begin
      if ((bootState_q == GPB_BOOT_RESTORE) && nvLoadValid
          && (nvLoadIdx < `GPB_UV_NV_COUNT))
         userVar[nvLoadIdx] <= nvLoadData;
      else if (isWrite && (req.bank == `GPB_BANK_USERVAR))
         userVar[req.param] <= req.value;
   end

   // periodic timers; period zero keeps a timer idle
   for (genvar t = 0; t < NTMR; t++)
   begin : g_tmr
      always_ff @(posedge core_clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            period_q[t] <= `GPB_RST_WORD;
            tcnt_q[t]   <= `GPB_RST_WORD;
         end
         else if (wrHit(`GPB_BANK_IRQ, IRQ_NUMS[t]))
         begin
            period_q[t] <= req.value;
            tcnt_q[t]   <= `GPB_RST_WORD;
         end
         else if (msTick)
         begin
            if ((period_q[t] == 32'h0) || (tcnt_q[t] >= period_q[t] - 32'h1))
               tcnt_q[t] <= `GPB_RST_WORD;
            else
               tcnt_q[t] <= tcnt_q[t] + 32'h1;
         end
      end
      assign fire[t] = msTick && (period_q[t] != 32'h0)
                       && (tcnt_q[t] >= period_q[t] - 32'h1);
   end

   assign pinRaw = {input1Pin, input0Pin, stopRightPin, stopLeftPin};

   // edge inputs: two-stage sync, then compare with previous sample
   for (genvar p = 0; p < NPIN; p++)
   begin : g_pin
      always_ff @(posedge core_clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            sync1_q[p]   <= 1'b0;
            sync2_q[p]   <= 1'b0;
            prev_q[p]    <= 1'b0;
            edgeSel_q[p] <= `GPB_EDGE_OFF;
         end
         else
         begin
            sync1_q[p] <= pinRaw[p];
            sync2_q[p] <= sync1_q[p];
            prev_q[p]  <= sync2_q[p];
            if (wrHit(`GPB_BANK_IRQ, IRQ_NUMS[NTMR + p]))
               edgeSel_q[p] <= req.value[1:0];
         end
      end
      // bit 0 of the code picks rising, bit 1 falling
      assign fire[NTMR + p] = (edgeSel_q[p][0] && sync2_q[p] && !prev_q[p])
                              || (edgeSel_q[p][1] && !sync2_q[p] && prev_q[p]);
   end

   // pending flags; a new event beats the acknowledge of the same slot
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         pend_q <= '0;
      else
         pend_q <= (pend_q & ~((irqAck && irqValid) ? (NIRQ'(1) << servIdx) : '0)) | fire;
   end
   assign servIdx  = lowestIdx(pend_q);
   assign irqValid = |pend_q;
   assign irqNum   = irqValid ? IRQ_NUMS[servIdx] : 8'h00;

   // read mux and error decode
   always_comb
   begin
      rdData = `GPB_RST_WORD;
      rdErr  = 1'b0;
      case (req.bank)
         `GPB_BANK_GLOBAL:
            case (req.param)
               `GPB_P_PROTECT:  rdData = {30'h0, protect_q};
               `GPB_P_COORD:    rdData = {31'h0, coord_q};
               `GPB_P_INHIBIT:  rdData = {31'h0, inhibit_q};
               `GPB_P_SECADDR:  rdData = {24'h0, secAddr_q};
               `GPB_P_REVERSE:  rdData = {31'h0, reverse_q};
               `GPB_P_APPSTATE: rdData = {30'h0, appState};
               `GPB_P_LOADMODE: rdData = {31'h0, loadMode};
               `GPB_P_PC:       rdData = progCounter;
               `GPB_P_TICK:     rdData = tick_q;
               `GPB_P_RANDOM:   rdData = {1'b0, rnd_q[30:0]};
               `GPB_P_SUPPRESS: rdData = {31'h0, suppress_q};
               default:         rdErr = 1'b1;
            endcase
         `GPB_BANK_USERVAR:
            rdData = userVar[req.param];
         `GPB_BANK_IRQ:
            case (req.param)
               `GPB_P_TIMER0:    rdData = period_q[0];
               `GPB_P_TIMER1:    rdData = period_q[1];
               `GPB_P_TIMER2:    rdData = period_q[2];
               `GPB_P_STOPLEFT:  rdData = {30'h0, edgeSel_q[0]};
               `GPB_P_STOPRIGHT: rdData = {30'h0, edgeSel_q[1]};
               `GPB_P_INPUT0:    rdData = {30'h0, edgeSel_q[2]};
               `GPB_P_INPUT1:    rdData = {30'h0, edgeSel_q[3]};
               default:          rdErr = 1'b1;
            endcase
         default:
            rdErr = 1'b1;
      endcase
      // status parameters refuse writes
      if ((req.cmd == GPB_WRITE_GLOBAL_PARAM_CMD) && (req.bank == `GPB_BANK_GLOBAL)
          && ((req.param == `GPB_P_APPSTATE) || (req.param == `GPB_P_LOADMODE)
              || (req.param == `GPB_P_PC)))
         rdErr = 1'b1;
   end

   // the three read commands always answer
   assign replyOk = !suppress_q || (req.cmd == GPB_READ_GLOBAL_PARAM_CMD)
                    || (req.cmd == GPB_READ_AXIS_PARAM_CMD)
                    || (req.cmd == GPB_READ_IO_CMD);

   // answer register, one cycle after the command
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rsp <= '0;
      else
      begin
         rsp.valid     <= acc;
         rsp.sendReply <= acc && replyOk;
         rsp.error     <= acc && (isRead || isWrite) && rdErr;
         rsp.data      <= isRead ? rdData : `GPB_RST_WORD;
      end
   end

   // checks
   property p_erase;
      @(posedge core_clk) disable iff (!arst_n)
      (isWrite && (req.bank == `GPB_BANK_GLOBAL) && (req.param == `GPB_P_PROTECT)
       && protect_q[0] && !req.value[0])
      |=> eraseProgramReq ##1 !eraseProgramReq;
   endproperty
   a_erase: assert property (p_erase) else $error("no erase on unlock");
   property p_coord;
      @(posedge core_clk) disable iff (!arst_n) coordNvWrite |-> coordWrite && coord_q;
   endproperty
   a_coord: assert property (p_coord) else $error("stray nv coordinate write");
   property p_boot;
      @(posedge core_clk) disable iff (!arst_n)
      (bootState_q == GPB_BOOT_WAIT) && nvInhibitRestore |=> !restoreReq && reqReady;
   endproperty
   a_boot: assert property (p_boot) else $error("restore despite inhibit");
   property p_secaddr;
      @(posedge core_clk) disable iff (!arst_n)
      (secAddr_q == 8'h00) && (rxAddr != primaryAddr) |-> !addrMatch;
   endproperty
   a_secaddr: assert property (p_secaddr) else $error("zero second address matched");
   property p_stepdir;
      @(posedge core_clk) disable iff (!arst_n)
      stepDirMode |-> (motorDirOut == motorDirIn) && (encDirOut == encDirIn);
   endproperty
   a_stepdir: assert property (p_stepdir) else $error("reversal in step mode");
   property p_tick;
      @(posedge core_clk) disable iff (!arst_n)
      msTick && !(isWrite && (req.bank == `GPB_BANK_GLOBAL) && (req.param == `GPB_P_TICK))
      |=> tick_q == $past(tick_q) + 32'h1;
   endproperty
   a_tick: assert property (p_tick) else $error("tick did not advance");
   property p_rnd;
      @(posedge core_clk) disable iff (!arst_n)
      isRead && (req.bank == `GPB_BANK_GLOBAL) && (req.param == `GPB_P_RANDOM)
      |=> rnd_q != $past(rnd_q);
   endproperty
   a_rnd: assert property (p_rnd) else $error("random value repeated");
   property p_suppress;
      @(posedge core_clk) disable iff (!arst_n)
      rsp.valid && !rsp.sendReply |-> $past(suppress_q);
   endproperty
   a_suppress: assert property (p_suppress) else $error("reply dropped unsuppressed");
   property p_prio;
      @(posedge core_clk) disable iff (!arst_n)
      pend_q[0] |-> irqValid && (irqNum == `GPB_P_TIMER0);
   endproperty
   a_prio: assert property (p_prio) else $error("timer 0 not served first");
   property p_edgeoff;
      @(posedge core_clk) disable iff (!arst_n)
      (edgeSel_q[0] == `GPB_EDGE_OFF) |=> !$rose(pend_q[NTMR]);
   endproperty
   a_edgeoff: assert property (p_edgeoff) else $error("disabled input fired");
   c_erase: cover property (@(posedge core_clk) disable iff (!arst_n) eraseProgramReq);
   c_irq:   cover property (@(posedge core_clk) disable iff (!arst_n) irqValid && irqAck);
   c_timer: cover property (@(posedge core_clk) disable iff (!arst_n) fire[0]);
   c_quiet: cover property (@(posedge core_clk) disable iff (!arst_n)
                            rsp.valid && !rsp.sendReply);
endmodule : gpb_param_bank

//--- tb/gpb_host_model.sv
// host model that issues decoded command telegrams to the bank
`timescale 1ns/100ps
module gpb_host_model
   import gpb_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reqReady,
   input  wire gpb_rsp_type rsp,
   output gpb_req_type      req
);
   initial req = '0;
   // one command held until taken, answer caught in its single cycle
   task automatic cmd(input gpb_cmd_type k, input logic [7:0] b, input logic [7:0] p,
                      input logic [31:0] v, output gpb_rsp_type r);
      int n;
      @(negedge core_clk);
      req <= '{1'b1, k, b, p, v};
      for (n = 0; n < 50 && reqReady !== 1'b1; n++)
         @(negedge core_clk);
      @(negedge core_clk);
      // released bank, parameter and value carry junk, not the last value
      req <= '{1'b0, k, ~b, ~p, ~v};
      for (n = 0; n < 2 && rsp.valid !== 1'b1; n++)
         @(negedge core_clk);
      r = rsp;
   endtask : cmd
endmodule : gpb_host_model

//--- tb/gpb_param_bank_tb_top.sv
// self-checking bench for the parameter and interrupt setup bank
`timescale 1ns/100ps
module gpb_param_bank_tb_top
   import gpb_pkg::*;
;
   logic core_clk = 0, arst_n = 0, nvInhibitRestore = 0, restoreDone = 0;
   logic nvLoadValid = 0, coordWrite = 0, stepDirMode = 0, motorDirIn = 0, encDirIn = 0;
   logic loadMode = 0, stopLeftPin = 0, stopRightPin = 0, input0Pin = 0, input1Pin = 0;
   logic irqAck = 0, reqReady, restoreReq, eraseProgramReq, coordNvWrite, addrMatch;
   logic motorDirOut, encDirOut, irqValid;
   logic [7:0]  nvLoadIdx = 0, rxAddr = 0, primaryAddr = 8'h01, irqNum;
   logic [1:0]  appState = 0, protectionLevel;
   logic [31:0] nvLoadData = 0, progCounter = 32'h0000_0ABC, d1;
   gpb_req_type req;
   gpb_rsp_type rsp, r;
   int mismatches = 0, cmp_count = 0, eraseSeen = 0, n;
   always #5 core_clk = ~core_clk;
   // erase requests are one-cycle pulses, so count them as they pass
   always @(posedge core_clk) if (eraseProgramReq === 1'b1) eraseSeen++;
   gpb_param_bank #(.MS_CYCLES(10)) dut (.*);
   gpb_host_model host (.core_clk, .reqReady, .rsp, .req);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] b, input logic [7:0] p, input logic [31:0] v);
      host.cmd(GPB_WRITE_GLOBAL_PARAM_CMD, b, p, v, r);
      chk({r.valid, r.error}, 2'b10);
   endtask : wr
   task automatic rd(input logic [7:0] b, input logic [7:0] p, input logic [31:0] e);
      host.cmd(GPB_READ_GLOBAL_PARAM_CMD, b, p, 32'h0, r);
      chk({r.valid, r.error}, 2'b10);
      chk(r.data, e);
   endtask : rd
   // waits, bounded, for a given interrupt to be the one shown
   task automatic waitIrq(input logic [7:0] e);
      for (n = 0; n < 40 && {irqValid, irqNum} !== {1'b1, e}; n++)
         @(negedge core_clk);
      chk({irqValid, irqNum}, {1'b1, e});
      // a wait that ran out ends the run
      if ({irqValid, irqNum} !== {1'b1, e})
         results();
   endtask : waitIrq
   task automatic ack();
      irqAck = 1;
      @(negedge core_clk);
      irqAck = 0;
   endtask : ack
   // power-up with the given stored inhibit; loader offers the last
   // restorable slot and the first one past it
   task automatic boot(input logic inh);
      nvInhibitRestore = inh;
      arst_n = 0;
      repeat (6) @(negedge core_clk);
      arst_n = 1;
      @(negedge core_clk);
      chk({restoreReq, reqReady}, {!inh, inh});
      nvLoadValid = 1;
      nvLoadIdx = 8'h37;
      nvLoadData = 32'hCAFE_0037;
      @(negedge core_clk);
      nvLoadIdx = 8'h38;
      @(negedge core_clk);
      nvLoadValid = 0;
      restoreDone = 1;
      @(negedge core_clk);
      restoreDone = 0;
   endtask : boot
   task automatic results();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial
   begin
      boot(1'b0);
      rd(8'h02, 8'h37, 32'hCAFE_0037);
      wr(8'h02, 8'hFF, 32'hFFFF_FFFE);
      rd(8'h02, 8'hFF, 32'hFFFF_FFFE);
      rd(8'h00, 8'hFF, 32'h0);
      wr(8'h00, 8'h51, 32'h3);
      wr(8'h00, 8'h51, 32'h2);
      repeat (2) @(negedge core_clk);
      chk(eraseSeen, 1);
      rd(8'h00, 8'h51, 32'h2);
      wr(8'h00, 8'h51, 32'h0);
      chk({eraseSeen[1:0], protectionLevel}, 4'h4);
      wr(8'h00, 8'h54, 32'h1);
      rd(8'h00, 8'h54, 32'h1);
      coordWrite = 1;
      #1 chk(coordNvWrite, 1'b1);
      coordWrite = 0;
      wr(8'h00, 8'h57, 32'h22);
      rxAddr = 8'h22;
      #1 chk(addrMatch, 1'b1);
      wr(8'h00, 8'h57, 32'h0);
      rxAddr = 8'h00;
      #1 chk(addrMatch, 1'b0);
      wr(8'h00, 8'h5A, 32'h1);
      {motorDirIn, encDirIn} = 2'b11;
      #1 chk({motorDirOut, encDirOut}, 2'b00);
      stepDirMode = 1;
      #1 chk({motorDirOut, encDirOut}, 2'b11);
      rd(8'h00, 8'h82, 32'h0000_0ABC);
      host.cmd(GPB_WRITE_GLOBAL_PARAM_CMD, 8'h00, 8'h82, 32'h1, r);
      chk(r.error, 1'b1);
      wr(8'h00, 8'h84, 32'h100);
      host.cmd(GPB_READ_GLOBAL_PARAM_CMD, 8'h00, 8'h84, 32'h0, r);
      chk(r.data inside {32'h100, 32'h101}, 1'b1);
      wr(8'h00, 8'h85, 32'h5);
      host.cmd(GPB_READ_GLOBAL_PARAM_CMD, 8'h00, 8'h85, 32'h0, r);
      d1 = r.data;
      host.cmd(GPB_READ_GLOBAL_PARAM_CMD, 8'h00, 8'h85, 32'h0, r);
      chk({d1[31], r.data !== d1}, 2'b01);
      wr(8'h00, 8'h85, 32'h5);
      rd(8'h00, 8'h85, d1);
      // suppressed replies, except for the three read kinds
      wr(8'h00, 8'hFF, 32'h1);
      host.cmd(GPB_OTHER_CMD, 8'h00, 8'h00, 32'h0, r);
      chk({r.valid, r.sendReply}, 2'b10);
      host.cmd(GPB_WRITE_GLOBAL_PARAM_CMD, 8'h00, 8'h54, 32'h0, r);
      chk({r.valid, r.sendReply}, 2'b10);
      for (int k = 2; k <= 4; k++)
      begin
         host.cmd(gpb_cmd_type'(k), 8'h00, 8'h54, 32'h0, r);
         chk({r.valid, r.sendReply}, 2'b11);
      end
      // coordinate persistence was cleared by the suppressed write
      coordWrite = 1;
      #1 chk(coordNvWrite, 1'b0);
      coordWrite = 0;
      wr(8'h00, 8'hFF, 32'h0);
      wr(8'h03, 8'h27, 32'h1);
      input0Pin = 1;
      waitIrq(8'h27);
      wr(8'h03, 8'h00, 32'h1);
      waitIrq(8'h00);
      wr(8'h03, 8'h00, 32'h0);
      ack();
      waitIrq(8'h27);
      ack();
      wr(8'h03, 8'h28, 32'h2);
      input1Pin = 1;
      repeat (6) @(negedge core_clk);
      chk(irqValid, 1'b0);
      input1Pin = 0;
      waitIrq(8'h28);
      ack();
      // mid-run power-ups: restore slot limit, then the inhibit
      wr(8'h02, 8'h37, 32'h1);
      wr(8'h02, 8'h38, 32'h2);
      wr(8'h00, 8'hFF, 32'h1);
      boot(1'b0);
      rd(8'h02, 8'h37, 32'hCAFE_0037);
      rd(8'h02, 8'h38, 32'h2);
      rd(8'h00, 8'hFF, 32'h0);
      wr(8'h02, 8'h37, 32'h1);
      boot(1'b1);
      rd(8'h02, 8'h37, 32'h1);
      rd(8'h00, 8'h55, 32'h1);
      results();
   end
   // overall cycle limit; running out counts as a failure
   initial
   begin
      repeat (5000) @(negedge core_clk);
      mismatches++;
      results();
   end
endmodule : gpb_param_bank_tb_top
